// file: verilog/mcsd_regs.svh
// Register offsets, field positions and sizes of the microcore block
`ifndef MCSD_REGS_SVH
`define MCSD_REGS_SVH
`define MCSD_ADDR_W 9
`define MCSD_NOUT 12
`define MCSD_NREGS 8
`define MCSD_OFS_GRANT_A 9'h184
`define MCSD_OFS_GRANT_B 9'h185
`define MCSD_OFS_GRANT_C 9'h186
`define MCSD_OFS_GRANT_D 9'h187
`define MCSD_OFS_HS_SLEW 9'h18e
`define MCSD_OFS_LS_SLEW 9'h18f
`define MCSD_OFS_LO_THR 9'h1a1
`define MCSD_OFS_HI_THR 9'h1a2
`define MCSD_OFS_COND 9'h1f0
`define MCSD_OFS_PROD_LO 9'h1f1
`define MCSD_OFS_PROD_HI 9'h1f2
`define MCSD_OFS_ALU_BASE 9'h1f8
`define MCSD_COND_DONE 0
`define MCSD_COND_SOUT 1
`define MCSD_COND_POVF 2
`define MCSD_COND_PLOSS 3
`define MCSD_COND_CSIGN 4
`define MCSD_COND_CFG 5
`define MCSD_IMM_AMT 3:0
`define MCSD_IMM_IDX 3:0
`define MCSD_IMM_ONE_LVL 4
`define MCSD_IMM_GRP_LVL 3
`define MCSD_IMM_GRP_SEL 2:0
`define MCSD_IMM_BIAS_SEL 11:0
`define MCSD_IMM_BIAS_ON 12
`define MCSD_IMM_FLAG 0
`define MCSD_IMM_CFG 1:0
`define MCSD_SC_W 4
`define MCSD_LS7 11
`endif

// file: verilog/mcsd_pkg.sv
// Types shared by the microcore block
package mcsd_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_LOAD, OP_LOAD_PROD,
      OP_P_SHL_R, OP_P_SHR_R, OP_P_SHL_I, OP_P_SHR_I,
      OP_W_SHL_R, OP_W_SHR_R, OP_W_SHL_I, OP_W_SHR_I,
      OP_W_WORD_SHIFT_LEFT_BYTE, OP_W_WORD_SHIFT_RIGHT_BYTE,
      OP_S_SHL_R, OP_S_SHR_R, OP_S_SHL_I, OP_S_SHR_I,
      OP_SWAP, OP_TO_TWOS, OP_TO_UNS, OP_ALU_CFG,
      OP_DEF_SC, OP_SET_ONE, OP_SET_GRP, OP_SLEW, OP_EOA,
      OP_BIAS, OP_DCDC
   } mcsd_op_t;
   typedef struct packed {
      mcsd_op_t op;
      logic [2:0] dst;
      logic [2:0] src;
      logic [15:0] imm;
   } mcsd_instr_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [8:0] addr;
      logic [15:0] wdata;
   } mcsd_bus_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SHIFT = 2'b10
   } mcsd_state_t;
endpackage : mcsd_pkg

// file: verilog/mcsd_core.sv
// Microcore shift, conversion and pre-driver configuration logic
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
// Notes on behaviour
// [RULE1] Multi-position shift lasts as many cycles as the shift amount.
// [RULE2] While shifting: done low, result held back, ALU ops except config dropped.
// [RULE3] Shift result goes back to the register that was shifted.
// [RULE4] Shift reports shift-out, product overflow, precision loss, done.
// [RULE5] Product shift by register amount; three loads precede it.
// [RULE6] Product shift by 4-bit immediate; two loads precede it.
// [RULE7] Word shifts by register amount or by 4-bit immediate.
// [RULE8] Byte shifts move a word by 8 in one cycle.
// [RULE9] Signed shifts by register amount treat the word as signed.
// [RULE10] Signed shifts by 4-bit immediate; one load precedes it.
// [RULE11] Swap exchanges bytes in place in one cycle.
// [RULE12] To-twos sets word MSB from last sign; conversions take one cycle.
// [RULE13] To-unsigned updates last sign, by XOR or by replacement.
// [RULE14] Three output shortcuts are recorded in one cycle.
// [RULE15] Single output set directly, no shortcut, one cycle.
// [RULE16] Group set uses shortcuts, which the program defines beforehand.
// [RULE17] Output commands act only where the access grant allows.
// [RULE18] Global slew forces maximum or restores configured rates.
// [RULE19] End-of-actuation mode is enabled in one cycle.
// [RULE20] One bias op turns its selected structures all on or all off.
// [RULE21] Bias only touches pre-drivers this core is granted.
// [RULE22] Asynchronous mode regulates LS7 between low and high thresholds.
// [RULE23] Synchronous mode leaves LS7 to the core's own commands.
// [RULE24] Single-cycle ops finish in one cycle; multiply is not here.
// [RULE25] Unsigned shifts zero-fill; signed right shifts copy the sign.
// [RULE26] Zero-amount shift changes nothing and reads as complete.
module mcsd_core #(
   parameter int CORE_SEL = 0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction port
   input wire logic instr_valid,
   input wire mcsd_pkg::mcsd_instr_t instr,
   output logic op_done,
   // Register port
   input wire mcsd_pkg::mcsd_bus_t bus,
   output logic [15:0] rdata,
   // Current measured by block four
   input wire logic [15:0] cur4_meas,
   // Pre-driver controls
   output logic [`MCSD_NOUT-1:0] cmd_out,
   output logic [`MCSD_NOUT-1:0] bias_out,
   output logic [15:0] hs_slew_out,
   output logic [15:0] ls_slew_out,
   output logic eoa_mode
);
   import mcsd_pkg::*;
   localparam int NOUT = `MCSD_NOUT;

   if (CORE_SEL < 0 || CORE_SEL > 3) begin : g_chk
      $error("CORE_SEL must be 0 to 3");
   end

   function automatic logic [NOUT-1:0] out_bit(input logic [3:0] idx);
      out_bit = (idx < 4'(NOUT)) ? (NOUT'(1) << idx) : '0;
   endfunction : out_bit

   function automatic logic [31:0] step1(input logic [31:0] w,
      input logic prod, input logic left, input logic sgn);
      if (left) begin
         step1 = prod ? {w[30:0], 1'b0} : {16'h0000, w[14:0], 1'b0};
      end else begin
         step1 = prod ? {1'b0, w[31:1]} :
                 {16'h0000, sgn & w[15], w[15:1]};
      end
   endfunction : step1

   logic [15:0] regs_q [`MCSD_NREGS];
   logic [31:0] prod_q;
   mcsd_state_t st_q;
   logic [15:0] cnt_q;
   logic [31:0] work_q;
   logic [2:0] widx_q;
   logic wprod_q, wleft_q, wsgn_q;
   logic done_q, sout_q, povf_q, ploss_q, csign_q;
   logic [1:0] cfg_q;
   logic [3:0] sc_q [3];
   logic [NOUT-1:0] cmd_q, bias_q;
   logic slew_max_q, eoa_q, async_q, ls7_auto_q;
   logic [15:0] grant_q [4];
   logic [15:0] hs_slew_q, ls_slew_q, lo_thr_q, hi_thr_q, rdata_q;

   // Decode
   mcsd_op_t op;
   assign op = instr.op;
   wire logic busy = (st_q == ST_SHIFT);
   wire logic is_alu = (op <= OP_ALU_CFG);
   // Shifts lock out the ALU, but the config op still lands [RULE2]
   wire logic take = instr_valid && (!busy || !is_alu || op == OP_ALU_CFG);
   wire logic is_sh = (op >= OP_P_SHL_R && op <= OP_S_SHR_I)
                      && op != OP_W_WORD_SHIFT_LEFT_BYTE && op != OP_W_WORD_SHIFT_RIGHT_BYTE;
   wire logic sh_prod = (op <= OP_P_SHR_I);
   wire logic sh_left = (op == OP_P_SHL_R) || (op == OP_P_SHL_I) ||
                        (op == OP_W_SHL_R) || (op == OP_W_SHL_I) ||
                        (op == OP_S_SHL_R) || (op == OP_S_SHL_I);
   wire logic sh_sgn = (op >= OP_S_SHL_R);
   wire logic sh_reg = (op == OP_P_SHL_R) || (op == OP_P_SHR_R) ||
                       (op == OP_W_SHL_R) || (op == OP_W_SHR_R) ||
                       (op == OP_S_SHL_R) || (op == OP_S_SHR_R);
   wire logic [15:0] dst_w = regs_q[instr.dst];
   wire logic [15:0] src_w = regs_q[instr.src];
   // Register or immediate amount [RULE5] [RULE6] [RULE7] [RULE9] [RULE10]
   wire logic [15:0] amt = sh_reg ? src_w :
                           {12'h000, instr.imm[`MCSD_IMM_AMT]};
   wire logic go_sh = take && is_sh;
   wire logic last = busy && (cnt_q == 16'h0001);
   wire logic [31:0] next_w = step1(work_q, wprod_q, wleft_q, wsgn_q);
   wire logic out_b = wleft_q ? (wprod_q ? work_q[31] : work_q[15])
                              : work_q[0];
   wire logic [NOUT-1:0] grant_w = grant_q[CORE_SEL][NOUT-1:0];

   // Output actuation masks
   wire logic [NOUT-1:0] grp_m =
      (instr.imm[0] ? out_bit(sc_q[0]) : '0) |
      (instr.imm[1] ? out_bit(sc_q[1]) : '0) |
      (instr.imm[2] ? out_bit(sc_q[2]) : '0);
   wire logic set_one = take && op == OP_SET_ONE;
   wire logic set_grp = take && op == OP_SET_GRP;
   // Direct single output [RULE15]; shortcut group [RULE16]
   wire logic [NOUT-1:0] act_m =
      set_one ? out_bit(instr.imm[`MCSD_IMM_IDX]) :
      set_grp ? grp_m : '0;
   wire logic act_lvl = set_one ? instr.imm[`MCSD_IMM_ONE_LVL]
                                : instr.imm[`MCSD_IMM_GRP_LVL];
   // Grant gates every actuation [RULE17]
   wire logic [NOUT-1:0] act_g = act_m & grant_w;
   // Bias only where granted [RULE21]
   wire logic [NOUT-1:0] bias_m =
      (take && op == OP_BIAS) ?
      instr.imm[`MCSD_IMM_BIAS_SEL] & grant_w : '0;

   // Overflow and loss flags are sticky within one shift, cleared by the next shift of nonzero amount
   // Shift sequencer and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 16'h0000;
         work_q <= 32'h0000_0000;
         widx_q <= 3'h0;
         {wprod_q, wleft_q, wsgn_q} <= 3'h0;
         {done_q, sout_q, povf_q, ploss_q} <= 4'h8;
      end else if (go_sh && amt != 16'h0000) begin
         st_q <= ST_SHIFT;
         cnt_q <= amt;
         work_q <= sh_prod ? prod_q : {16'h0000, dst_w};
         widx_q <= instr.dst;
         {wprod_q, wleft_q, wsgn_q} <= {sh_prod, sh_left, sh_sgn};
         {done_q, sout_q, povf_q, ploss_q} <= 4'h0; // [RULE2]
      end else if (busy) begin
         work_q <= next_w; // [RULE1] [RULE25]
         cnt_q <= cnt_q - 16'h0001;
         sout_q <= out_b; // [RULE4]
         povf_q <= povf_q | (wprod_q & wleft_q & out_b);
         ploss_q <= ploss_q | (wprod_q & !wleft_q & out_b);
         if (last) begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
         end
      end else if (go_sh) begin
         done_q <= 1'b1; // Zero amount [RULE26]
      end
   end

   // ALU registers, product register, conversion sign
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `MCSD_NREGS; i++) begin
            regs_q[i] <= 16'h0000;
         end
         prod_q <= 32'h0000_0000;
         csign_q <= 1'b0;
         cfg_q <= 2'h0;
      end else begin
         if (take && op == OP_ALU_CFG) begin
            cfg_q <= instr.imm[`MCSD_IMM_CFG];
         end
         if (last) begin
            // In-place write-back [RULE3]
            if (wprod_q) begin
               prod_q <= next_w;
            end else begin
               regs_q[widx_q] <= next_w[15:0];
            end
         end else if (take) begin
            case (op)
               OP_LOAD: regs_q[instr.dst] <= instr.imm;
               OP_LOAD_PROD: prod_q <= {dst_w, src_w};
               OP_W_WORD_SHIFT_LEFT_BYTE: regs_q[instr.dst] <= {dst_w[7:0], 8'h00}; // [RULE8]
               OP_W_WORD_SHIFT_RIGHT_BYTE: regs_q[instr.dst] <= {8'h00, dst_w[15:8]}; // [RULE8]
               OP_SWAP: regs_q[instr.dst] <= {dst_w[7:0], dst_w[15:8]}; // [RULE11]
               OP_TO_TWOS: regs_q[instr.dst][15] <= csign_q; // [RULE12]
               OP_TO_UNS: begin
                  regs_q[instr.dst][15] <= 1'b0;
                  csign_q <= instr.imm[`MCSD_IMM_FLAG] ? dst_w[15]
                             : csign_q ^ dst_w[15]; // [RULE13]
               end
               default: ;
            endcase
         end
      end
   end

   // Pre-driver configuration, each op a single cycle [RULE24]
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            sc_q[i] <= 4'h0;
         end
         cmd_q <= '0;
         bias_q <= '0;
         {slew_max_q, eoa_q, async_q} <= 3'h0;
      end else begin
         if (take && op == OP_DEF_SC) begin
            for (int i = 0; i < 3; i++) begin
               sc_q[i] <= instr.imm[i*`MCSD_SC_W +: `MCSD_SC_W]; // [RULE14]
            end
         end
         cmd_q <= (cmd_q & ~act_g) | (act_g & {NOUT{act_lvl}}); // [RULE17]
         // All selected on, or all off [RULE20]
         bias_q <= instr.imm[`MCSD_IMM_BIAS_ON] ? (bias_q | bias_m)
                   : (bias_q & ~bias_m);
         if (take && op == OP_SLEW) begin
            slew_max_q <= instr.imm[`MCSD_IMM_FLAG]; // [RULE18]
         end
         if (take && op == OP_EOA) begin
            eoa_q <= instr.imm[`MCSD_IMM_FLAG]; // [RULE19]
         end
         if (take && op == OP_DCDC) begin
            async_q <= instr.imm[`MCSD_IMM_FLAG]; // [RULE22] [RULE23]
         end
      end
   end

   // High threshold wins if software sets the two thresholds crossed
   // Hysteretic LS7 regulation on the block-four current [RULE22]
   always_ff @(posedge clk) begin
      if (rst) begin
         ls7_auto_q <= 1'b0;
      end else if (cur4_meas >= hi_thr_q) begin
         ls7_auto_q <= 1'b0;
      end else if (cur4_meas <= lo_thr_q) begin
         ls7_auto_q <= 1'b1;
      end
   end

   // Register port
   wire logic [`MCSD_ADDR_W-1:0] a = bus.addr;
   wire logic in_alu = (a >= `MCSD_OFS_ALU_BASE);
   // ALU registers are read-only here, so software cannot upset a shift
   wire logic [2:0] alu_i = 3'(a - `MCSD_OFS_ALU_BASE);
   wire logic [15:0] cond_w = 16'({cfg_q, csign_q, ploss_q, povf_q,
                                   sout_q, done_q});
   logic [15:0] rd_w;
   always_comb begin
      case (a)
         `MCSD_OFS_GRANT_A: rd_w = grant_q[0];
         `MCSD_OFS_GRANT_B: rd_w = grant_q[1];
         `MCSD_OFS_GRANT_C: rd_w = grant_q[2];
         `MCSD_OFS_GRANT_D: rd_w = grant_q[3];
         `MCSD_OFS_HS_SLEW: rd_w = hs_slew_q;
         `MCSD_OFS_LS_SLEW: rd_w = ls_slew_q;
         `MCSD_OFS_LO_THR: rd_w = lo_thr_q;
         `MCSD_OFS_HI_THR: rd_w = hi_thr_q;
         `MCSD_OFS_COND: rd_w = cond_w; // [RULE4]
         `MCSD_OFS_PROD_LO: rd_w = prod_q[15:0];
         `MCSD_OFS_PROD_HI: rd_w = prod_q[31:16];
         default: rd_w = in_alu ? regs_q[alu_i] : 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            grant_q[i] <= 16'h0000;
         end
         {hs_slew_q, ls_slew_q} <= 32'h0000_0000;
         {lo_thr_q, hi_thr_q} <= 32'h0000_0000;
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= bus.rd ? rd_w : 16'h0000;
         if (bus.wr) begin
            case (a)
               `MCSD_OFS_GRANT_A: grant_q[0] <= bus.wdata;
               `MCSD_OFS_GRANT_B: grant_q[1] <= bus.wdata;
               `MCSD_OFS_GRANT_C: grant_q[2] <= bus.wdata;
               `MCSD_OFS_GRANT_D: grant_q[3] <= bus.wdata;
               `MCSD_OFS_HS_SLEW: hs_slew_q <= bus.wdata;
               `MCSD_OFS_LS_SLEW: ls_slew_q <= bus.wdata;
               `MCSD_OFS_LO_THR: lo_thr_q <= bus.wdata;
               `MCSD_OFS_HI_THR: hi_thr_q <= bus.wdata;
               default: ;
            endcase
         end
      end
   end

   // Outputs; LS7 source follows the DC-DC mode [RULE22] [RULE23]
   assign op_done = done_q;
   assign rdata = rdata_q;
   assign cmd_out = async_q ? {ls7_auto_q, cmd_q[NOUT-2:0]} : cmd_q;
   assign bias_out = bias_q;
   assign hs_slew_out = slew_max_q ? 16'hffff : hs_slew_q; // [RULE18]
   assign ls_slew_out = slew_max_q ? 16'hffff : ls_slew_q;
   assign eoa_mode = eoa_q;

   // Checks
   AST_SHIFT_HOLDS: assert property (@(posedge clk) disable iff (rst) // [RULE1]
      busy && cnt_q > 16'h0001 |=> busy && cnt_q == $past(cnt_q) - 16'h0001)
      else $error("shift ended early");
   AST_DONE_LOW: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      busy |-> !op_done && $stable(prod_q))
      else $error("result exposed mid-shift");
   AST_DROP_LOAD: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      busy && !last && instr_valid && op == OP_LOAD
      |=> regs_q[$past(instr.dst)] == $past(dst_w))
      else $error("load taken mid-shift");
   AST_ONE_STEP: assert property (@(posedge clk) disable iff (rst) // [RULE8]
      take && op == OP_W_WORD_SHIFT_LEFT_BYTE |=> !busy ##0
      regs_q[$past(instr.dst)] == {$past(dst_w[7:0]), 8'h00})
      else $error("byte shift wrong");
   AST_SWAP: assert property (@(posedge clk) disable iff (rst) // [RULE11]
      take && op == OP_SWAP
      |=> regs_q[$past(instr.dst)] == {$past(dst_w[7:0]), $past(dst_w[15:8])})
      else $error("swap wrong");
   AST_GRANT: assert property (@(posedge clk) disable iff (rst) // [RULE17]
      ((cmd_q ^ $past(cmd_q)) & ~$past(grant_w)) == '0)
      else $error("ungranted output moved");
   AST_ZERO_AMT: assert property (@(posedge clk) disable iff (rst) // [RULE26]
      go_sh && !busy && amt == 16'h0000 |=> !busy && op_done)
      else $error("zero shift not complete");
   AST_WB_LEN: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      go_sh && !busy && !sh_prod && sh_left && amt == 16'h0002
      |=> busy ##1 busy ##1 !busy && op_done &&
      regs_q[$past(instr.dst, 3)] == {$past(dst_w[13:0], 3), 2'b00})
      else $error("two-step shift wrong");
   AST_SYNC_LS7: assert property (@(posedge clk) disable iff (rst) // [RULE23]
      !async_q && !$past(async_q) && !$past(act_g[`MCSD_LS7])
      |-> $stable(cmd_out[`MCSD_LS7]))
      else $error("LS7 moved without a core command");
   AST_CFG_OK: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      busy && instr_valid && op == OP_ALU_CFG
      |=> cfg_q == $past(instr.imm[`MCSD_IMM_CFG]))
      else $error("config op lost mid-shift");
   AST_END_OK: assert property (@(posedge clk) disable iff (rst) // [RULE4]
      last |=> !busy && op_done)
      else $error("shift did not report done");
   AST_WORD_SHIFT_RIGHT_BYTE: assert property (@(posedge clk) disable iff (rst) // [RULE8]
      take && op == OP_W_WORD_SHIFT_RIGHT_BYTE |=> !busy ##0
      regs_q[$past(instr.dst)] == {8'h00, $past(dst_w[15:8])})
      else $error("byte right shift wrong");
   AST_TWOS: assert property (@(posedge clk) disable iff (rst) // [RULE12]
      take && op == OP_TO_TWOS
      |=> regs_q[$past(instr.dst)] == {$past(csign_q), $past(dst_w[14:0])})
      else $error("to-twos sign wrong");
   AST_UNS: assert property (@(posedge clk) disable iff (rst) // [RULE13]
      take && op == OP_TO_UNS
      |=> csign_q == ($past(instr.imm[`MCSD_IMM_FLAG]) ? $past(dst_w[15])
      : $past(csign_q) ^ $past(dst_w[15])))
      else $error("last sign wrong");
   AST_BIAS_G: assert property (@(posedge clk) disable iff (rst) // [RULE21]
      ((bias_q ^ $past(bias_q)) & ~$past(grant_w)) == '0)
      else $error("ungranted bias moved");
   AST_LS7_ON: assert property (@(posedge clk) disable iff (rst) // [RULE22]
      cur4_meas <= lo_thr_q && cur4_meas < hi_thr_q |=> ls7_auto_q)
      else $error("LS7 regulation missed low threshold");
endmodule : mcsd_core
`default_nettype wire

// file: verification/mcsd_seq_model.sv
// Instruction sequencer model driving the microcore instruction port
`timescale 1ns/1ps
`default_nettype none
module mcsd_seq_model (
   // Clock
   input wire logic clk,
   // Instruction port
   output logic instr_valid,
   output mcsd_pkg::mcsd_instr_t instr,
   input wire logic op_done
);
   import mcsd_pkg::*;
   initial begin
      instr_valid = 1'b0;
      instr = '0;
   end
   // One instruction, held only for the edge that takes it
   task automatic issue(input mcsd_op_t o, input logic [2:0] d,
      input logic [2:0] s, input logic [15:0] imm);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= '{op: o, dst: d, src: s, imm: imm};
      @(posedge clk);
      instr_valid <= 1'b0;
      // Idle fields scrambled so a stale instruction never looks valid
      instr <= '{op: OP_NOP, dst: ~d, src: ~s, imm: ~imm};
   endtask : issue
   // Poll done before the next ALU op, bounded wait
   task automatic wait_done(output int n);
      n = 0;
      #1;
      while (op_done !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_done
endmodule : mcsd_seq_model
`default_nettype wire

// file: verification/test_mcsd_core.sv
// Self-checking bench for the microcore shift and driver logic
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module test_mcsd_core;
   import mcsd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic instr_valid;
   mcsd_instr_t instr;
   logic op_done;
   mcsd_bus_t bus = '0;
   logic [15:0] rdata;
   logic [15:0] cur4_meas = 16'h0000;
   logic [`MCSD_NOUT-1:0] cmd_out;
   logic [`MCSD_NOUT-1:0] bias_out;
   logic [15:0] hs_slew_out;
   logic [15:0] ls_slew_out;
   logic eoa_mode;
   int miscompares = 0;
   int cmp_count = 0;
   int n;
   logic [15:0] v;
   always #12.5 clk = ~clk;
   mcsd_core #(.CORE_SEL(0)) u_mcsd_core (.clk(clk), .rst(rst),
      .instr_valid(instr_valid), .instr(instr), .op_done(op_done),
      .bus(bus), .rdata(rdata), .cur4_meas(cur4_meas),
      .cmd_out(cmd_out), .bias_out(bias_out), .hs_slew_out(hs_slew_out),
      .ls_slew_out(ls_slew_out), .eoa_mode(eoa_mode));
   mcsd_seq_model u_mcsd_seq_model (.clk(clk), .instr_valid(instr_valid),
      .instr(instr), .op_done(op_done));
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [8:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
      #1;
      v = rdata;
      chk({16'h0000, v}, {16'h0000, exp});
   endtask : rchk
   task automatic op(input mcsd_op_t o, input logic [2:0] d,
      input logic [2:0] s, input logic [15:0] imm);
      u_mcsd_seq_model.issue(o, d, s, imm);
      #1;
   endtask : op
   // Shift, then cycle count and result in place
   task automatic sh(input mcsd_op_t o, input logic [2:0] d,
      input logic [2:0] s, input logic [15:0] imm, input int en,
      input logic [15:0] ev);
      op(o, d, s, imm);
      u_mcsd_seq_model.wait_done(n);
      chk(n, en);
      rchk(`MCSD_OFS_ALU_BASE + {6'h00, d}, ev);
   endtask : sh
   task automatic t_regs;
      wr(`MCSD_OFS_GRANT_A, 16'h0ffb);
      rchk(`MCSD_OFS_GRANT_A, 16'h0ffb);
      wr(`MCSD_OFS_HS_SLEW, 16'h1234);
      wr(`MCSD_OFS_LS_SLEW, 16'h0567);
      rchk(`MCSD_OFS_LS_SLEW, 16'h0567);
      rchk(9'h100, 16'h0000);
   endtask : t_regs
   task automatic t_word;
      op(OP_LOAD, 3'h1, 3'h0, 16'ha421);
      op(OP_W_SHL_I, 3'h1, 3'h0, 16'h0003);
      // Load lands mid-shift and must be dropped
      op(OP_LOAD, 3'h1, 3'h0, 16'hffff);
      u_mcsd_seq_model.wait_done(n);
      chk(n, 1);
      rchk(`MCSD_OFS_ALU_BASE + 9'h001, 16'h2108);
      chk({31'h0, op_done}, 32'h1);
      rchk(`MCSD_OFS_COND, 16'h0003);
      op(OP_LOAD, 3'h2, 3'h0, 16'h0005);
      sh(OP_W_SHR_R, 3'h1, 3'h2, 16'h0000, 5, 16'h0108);
      wr(`MCSD_OFS_ALU_BASE + 9'h001, 16'hdead);
      sh(OP_W_SHL_I, 3'h1, 3'h0, 16'h0000, 0, 16'h0108);
      sh(OP_W_WORD_SHIFT_LEFT_BYTE, 3'h1, 3'h0, 16'h0000, 0, 16'h0800);
      sh(OP_W_WORD_SHIFT_RIGHT_BYTE, 3'h1, 3'h0, 16'h0000, 0, 16'h0008);
      sh(OP_W_SHL_I, 3'h1, 3'h0, 16'h0002, 2, 16'h0020);
      op(OP_LOAD, 3'h3, 3'h0, 16'h8010);
      sh(OP_S_SHR_I, 3'h3, 3'h0, 16'h0002, 2, 16'he004);
      sh(OP_S_SHL_R, 3'h3, 3'h2, 16'h0000, 5, 16'h0080);
      op(OP_LOAD, 3'h2, 3'h0, 16'h0001);
      sh(OP_S_SHR_R, 3'h3, 3'h2, 16'h0000, 1, 16'h0040);
      sh(OP_S_SHL_I, 3'h3, 3'h0, 16'h0004, 4, 16'h0400);
   endtask : t_word
   task automatic t_prod;
      op(OP_LOAD, 3'h1, 3'h0, 16'h1234);
      op(OP_LOAD, 3'h2, 3'h0, 16'h5678);
      op(OP_LOAD_PROD, 3'h1, 3'h2, 16'h0000);
      sh(OP_P_SHL_I, 3'h3, 3'h3, 16'h0004, 4, 16'h0400);
      rchk(`MCSD_OFS_PROD_HI, 16'h2345);
      rchk(`MCSD_OFS_PROD_LO, 16'h6780);
      rchk(`MCSD_OFS_COND, 16'h0007);
      op(OP_LOAD, 3'h3, 3'h0, 16'h0008);
      sh(OP_P_SHR_R, 3'h3, 3'h3, 16'h0000, 8, 16'h0008);
      rchk(`MCSD_OFS_PROD_LO, 16'h4567);
      rchk(`MCSD_OFS_PROD_HI, 16'h0023);
      rchk(`MCSD_OFS_COND, 16'h000b);
      sh(OP_P_SHL_R, 3'h3, 3'h3, 16'h0000, 8, 16'h0008);
      rchk(`MCSD_OFS_PROD_HI, 16'h2345);
      sh(OP_P_SHR_I, 3'h3, 3'h3, 16'h0004, 4, 16'h0008);
      rchk(`MCSD_OFS_PROD_LO, 16'h5670);
   endtask : t_prod
   task automatic t_conv;
      op(OP_LOAD, 3'h4, 3'h0, 16'h12ab);
      sh(OP_SWAP, 3'h4, 3'h4, 16'h0000, 0, 16'hab12);
      op(OP_LOAD, 3'h4, 3'h0, 16'h8005);
      sh(OP_TO_UNS, 3'h4, 3'h4, 16'h0001, 0, 16'h0005);
      rchk(`MCSD_OFS_COND, 16'h0011);
      sh(OP_TO_TWOS, 3'h4, 3'h4, 16'h0000, 0, 16'h8005);
      sh(OP_TO_UNS, 3'h4, 3'h4, 16'h0000, 0, 16'h0005);
      sh(OP_TO_TWOS, 3'h4, 3'h4, 16'h0000, 0, 16'h0005);
      // Config op lands while a shift is running
      op(OP_W_SHR_I, 3'h5, 3'h0, 16'h0004);
      op(OP_ALU_CFG, 3'h0, 3'h0, 16'h0002);
      u_mcsd_seq_model.wait_done(n);
      chk(n, 2);
      rchk(`MCSD_OFS_COND, 16'h0041);
   endtask : t_conv
   task automatic t_out;
      op(OP_SET_ONE, 3'h0, 3'h0, 16'h0010);
      op(OP_SET_ONE, 3'h0, 3'h0, 16'h0012);
      chk({20'h0, cmd_out}, 32'h001);
      // Shortcuts defined before any group set
      op(OP_DEF_SC, 3'h0, 3'h0, 16'h0521);
      op(OP_SET_GRP, 3'h0, 3'h0, 16'h000f);
      chk({20'h0, cmd_out}, 32'h023);
      op(OP_SET_GRP, 3'h0, 3'h0, 16'h0007);
      chk({20'h0, cmd_out}, 32'h001);
      op(OP_BIAS, 3'h0, 3'h0, 16'h1007);
      chk({20'h0, bias_out}, 32'h003);
      op(OP_BIAS, 3'h0, 3'h0, 16'h0001);
      chk({20'h0, bias_out}, 32'h002);
   endtask : t_out
   task automatic t_slew;
      op(OP_SLEW, 3'h0, 3'h0, 16'h0001);
      chk({hs_slew_out, ls_slew_out}, 32'hffffffff);
      op(OP_SLEW, 3'h0, 3'h0, 16'h0000);
      chk({hs_slew_out, ls_slew_out}, 32'h12340567);
      op(OP_EOA, 3'h0, 3'h0, 16'h0001);
      chk({31'h0, eoa_mode}, 32'h1);
   endtask : t_slew
   task automatic t_dcdc;
      wr(`MCSD_OFS_LO_THR, 16'h0100);
      wr(`MCSD_OFS_HI_THR, 16'h0200);
      @(posedge clk);
      cur4_meas <= 16'h0050;
      op(OP_DCDC, 3'h0, 3'h0, 16'h0001);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, cmd_out[`MCSD_LS7]}, 32'h1);
      @(posedge clk);
      cur4_meas <= 16'h0300;
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, cmd_out[`MCSD_LS7]}, 32'h0);
      op(OP_DCDC, 3'h0, 3'h0, 16'h0000);
      op(OP_SET_ONE, 3'h0, 3'h0, 16'h001b);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, cmd_out[`MCSD_LS7]}, 32'h1);
   endtask : t_dcdc
   initial begin
      #(25 * 20000);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({31'h0, op_done}, 32'h1);
      t_regs();
      t_word();
      t_prod();
      t_conv();
      t_out();
      t_slew();
      t_dcdc();
      end_sim();
   end
endmodule : test_mcsd_core
`default_nettype wire
